// file: hdl/pcd_cue_decoder.sv
/*
 Cue command decoder top: APB panel registers, staged entry, cue commit,
 program memory, play sequencer, tape port, aux outputs and three screen channels.
 Assumes a 25 MHz sys_clk, an APB master on the same clock and synchronous pins.
*/
`timescale 1ns/1ps
`include "pcd_defs.svh"
module pcd_cue_decoder
	import pcd_pkg::*;
#(
	parameter int unsigned SEQ_CYC         = `PCD_CLK_HZ / `PCD_SEQ_RATE_HZ,
	parameter int unsigned BLEND_SHORT_CYC = `PCD_BLEND_SHORT_S * `PCD_CLK_HZ / `PCD_LVL_STEPS,
	parameter int unsigned BLEND_MED_CYC   = `PCD_BLEND_MED_S * `PCD_CLK_HZ / `PCD_LVL_STEPS,
	parameter int unsigned BLEND_LONG_CYC  = `PCD_BLEND_LONG_S * `PCD_CLK_HZ / `PCD_LVL_STEPS
)(
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output wire logic [31:0] prdata,
	output wire logic        pready,
	output wire logic        pslverr,
	input  wire logic        remoteCue,
	output wire logic        remoteInd,
	output wire logic        isolateInd,
	input  wire logic        tapePlayValid,
	input  wire logic [8:0]  tapePlayData,
	output wire logic        tapeRecValid,
	output wire logic [8:0]  tapeRecData,
	output wire logic [47:0] lampLevel,
	output wire logic [5:0]  trayAdvance,
	output wire logic [5:0]  trayBack,
	output wire logic [2:0]  auxPulse,
	output wire logic        auxLatch,
	output wire logic [11:0] cueCount
);
	pcd_top_st_t st_r, st_nxt;
	pcd_entry_t  progMem [`PCD_MEM_DEPTH];
	pcd_entry_t  staged, ex, memAtIdx;
	logic        wrAcc, wrStage, commit, kbdGo, seqGo, tapeGo, exGo, store, memWe;
	logic        mapped, isoNxt;
	logic [5:0]  chanLit;
	logic [2:0]  chanBusy;
	logic [23:0] chanPos;
	logic [3:0]  lastIdx;

	pcd_chan_if chIf [3] ();

	function automatic logic [11:0] bcdInc(input logic [11:0] v);
		logic [11:0] r;
		r = v;
		if (r[3:0] != 4'h9) begin
			r[3:0] = r[3:0] + 4'h1;
		end else begin
			r[3:0] = 4'h0;
			if (r[7:4] != 4'h9) begin
				r[7:4] = r[7:4] + 4'h1;
			end else begin
				r[7:4] = 4'h0;
				r[11:8] = (r[11:8] == 4'h9) ? 4'h0 : r[11:8] + 4'h1;
			end
		end
		return r;
	endfunction

	assign memAtIdx = progMem[st_r.cueIdx];

	always_comb begin
		st_nxt = st_r;
		st_nxt.auxOut = 3'h0;
		st_nxt.recValid = 1'b0;
		wrAcc = psel && penable && pwrite;
		wrStage = wrAcc && paddr == `PCD_ADDR_STAGE;
		staged = wrStage ? (st_r.stage | pcd_entry_t'(pwdata[`PCD_STG_ENTRY_HI:0])) : st_r.stage;
		// The panel cue key and an enabled remote are the only keyboard commits.
		commit = (wrStage && pwdata[`PCD_STG_CUE]) || (remoteCue && !st_r.remIso);
		kbdGo = commit && (!st_r.seqRun || st_r.kbdOvr);
		seqGo = st_r.seqDue && !kbdGo;
		// A tape entry that meets a keyboard or sequence slot is dropped, not queued.
		tapeGo = tapePlayValid && st_r.tapeOn && !st_r.tapeRec && !kbdGo && !st_r.seqDue;
		exGo = kbdGo || seqGo || tapeGo;
		if (kbdGo)
			ex = staged;
		else if (seqGo)
			ex = memAtIdx;
		else if (tapeGo)
			ex = pcd_entry_t'(tapePlayData);
		else
			ex = '0;
		store = (kbdGo && !st_r.play) || tapeGo;
		memWe = store && !st_r.memIso;

		if (wrAcc && paddr == `PCD_ADDR_PANEL) begin
			st_nxt.kbdOvr = pwdata[`PCD_PNL_OVR];
			st_nxt.memIso = pwdata[`PCD_PNL_MEMISO];
			st_nxt.remIso = pwdata[`PCD_PNL_REMISO];
			st_nxt.dmode = pwdata[`PCD_PNL_DMODE_HI:`PCD_PNL_DMODE_LO];
			st_nxt.play = pwdata[`PCD_PNL_PLAY];
			st_nxt.tapeOn = pwdata[`PCD_PNL_TAPEON];
			st_nxt.tapeRec = pwdata[`PCD_PNL_TAPEREC];
			st_nxt.auxFit = pwdata[`PCD_PNL_AUXFIT];
		end
		if (wrStage)
			st_nxt.stage = staged;
		if (commit)
			st_nxt.stage = '0;

		if (store || seqGo) begin
			st_nxt.cueBcd = bcdInc(st_r.cueBcd);
			st_nxt.cueIdx = st_r.cueIdx + 4'h1;
		end
		if (seqGo) begin
			st_nxt.seqDue = 1'b0;
			if (ex.cmd == CMD_STOP)
				st_nxt.seqRun = 1'b0;
		end
		if (st_r.seqRun) begin
			if (st_r.seqCnt >= 24'(SEQ_CYC) - 24'h000001) begin
				st_nxt.seqCnt = 24'h000000;
				st_nxt.seqDue = 1'b1;
			end else begin
				st_nxt.seqCnt = st_r.seqCnt + 24'h000001;
			end
		end
		if (kbdGo && st_r.play && ex.cmd == CMD_START && !st_r.seqRun) begin
			st_nxt.seqRun = 1'b1;
			st_nxt.seqCnt = 24'h000000;
		end
		if (!st_r.play) begin
			st_nxt.seqRun = 1'b0;
			st_nxt.seqDue = 1'b0;
		end
		if (wrStage && pwdata[`PCD_STG_HOME]) begin
			st_nxt.cueBcd = `PCD_CUE_START;
			st_nxt.cueIdx = 4'h0;
			st_nxt.seqRun = 1'b0;
			st_nxt.seqDue = 1'b0;
		end

		isoNxt = st_nxt.dmode == DM_ISOLATE;
		if (exGo && ex.cmd == CMD_AUX) begin
			if (ex.screens != 3'h0)
				st_nxt.auxOut = isoNxt ? 3'h0 : ex.screens;
			else if (st_r.auxFit)
				st_nxt.auxLatchSt = !st_r.auxLatchSt;
		end
		st_nxt.auxLatchOut = st_nxt.auxLatchSt && !isoNxt;
		st_nxt.isoInd = isoNxt;
		st_nxt.remInd = remoteCue;
		if (exGo && st_r.tapeOn && st_r.tapeRec) begin
			st_nxt.recValid = 1'b1;
			st_nxt.recData = ex;
		end

		if (psel && !penable) begin
			unique case (paddr)
				`PCD_ADDR_PANEL: st_nxt.prdata = {23'h0, st_r.auxFit, st_r.tapeRec,
					st_r.tapeOn, st_r.play, st_r.dmode, st_r.remIso, st_r.memIso, st_r.kbdOvr};
				`PCD_ADDR_STAGE:  st_nxt.prdata = {23'h0, st_r.stage};
				`PCD_ADDR_STATUS: st_nxt.prdata = {9'h0, chanLit, chanBusy, st_r.seqRun,
					st_r.auxLatchSt, st_r.cueBcd};
				`PCD_ADDR_TRAY:   st_nxt.prdata = {8'h0, chanPos};
				default:          st_nxt.prdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			st_r <= '{cueBcd: `PCD_CUE_START, default: '0};
		else
			st_r <= st_nxt;
	end

	// Memory is cleared at reset so a sequence never replays stale entries.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int k = 0; k < `PCD_MEM_DEPTH; k++)
				progMem[k] <= '0;
		end else if (memWe) begin
			progMem[st_r.cueIdx] <= ex;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			lastIdx <= 4'h0;
		else
			lastIdx <= st_r.cueIdx;
	end

	for (genvar i = 0; i < 3; i++) begin : g_chan
		assign chIf[i].go         = exGo && ex.screens[i];
		assign chIf[i].cmd        = ex.cmd;
		assign chIf[i].selL       = ex.left;
		assign chIf[i].selR       = ex.right;
		assign chIf[i].lampsOff   = st_r.dmode == DM_STANDBY;
		assign chIf[i].outIsolate = st_r.dmode == DM_ISOLATE;
		assign lampLevel[16*i +: 16] = {chIf[i].lvlR, chIf[i].lvlL};
		assign trayAdvance[2*i +: 2] = {chIf[i].advR, chIf[i].advL};
		assign trayBack[2*i +: 2]    = {chIf[i].backR, chIf[i].backL};
		assign chanLit[2*i +: 2]     = {chIf[i].litR, chIf[i].litL};
		assign chanPos[8*i +: 8]     = {chIf[i].posR, chIf[i].posL};
		assign chanBusy[i]           = chIf[i].busy;
		pcd_channel #(
			.SHORT_CYC (BLEND_SHORT_CYC),
			.MED_CYC   (BLEND_MED_CYC),
			.LONG_CYC  (BLEND_LONG_CYC)
		) u_chan (
			.sys_clk (sys_clk),
			.reset_n (reset_n),
			.ch      (chIf[i].chan)
		);
	end

	assign mapped = paddr inside {`PCD_ADDR_PANEL, `PCD_ADDR_STAGE, `PCD_ADDR_STATUS,
		`PCD_ADDR_TRAY};
	assign pready       = 1'b1;
	assign pslverr      = psel && penable && !mapped;
	assign prdata       = st_r.prdata;
	assign remoteInd    = st_r.remInd;
	assign isolateInd   = st_r.isoInd;
	assign tapeRecValid = st_r.recValid;
	assign tapeRecData  = st_r.recData;
	assign auxPulse     = st_r.auxOut;
	assign auxLatch     = st_r.auxLatchOut;
	assign cueCount     = st_r.cueBcd;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_stage_only;
		wrStage && !pwdata[`PCD_STG_CUE] && !remoteCue;
	endsequence
	a_stage_no_exec: assert property (s_stage_only and (!st_r.seqDue && !tapePlayValid)
		|-> !exGo) else $error("staged entry executed early");
	a_commit_clears: assert property (commit && !wrStage |=> st_r.stage == '0)
		else $error("stage not cleared by cue");
	a_remote_light: assert property (remoteCue |=> remoteInd)
		else $error("remote indicator dark");
	a_remote_blocked: assert property (remoteCue && st_r.remIso && !wrStage && !st_r.seqDue
		&& !tapePlayValid |-> !exGo) else $error("isolated remote executed");
	a_isolate_quiet: assert property ($past(st_r.dmode) == DM_ISOLATE
		&& st_r.dmode == DM_ISOLATE |-> lampLevel == '0 && trayAdvance == '0
		&& trayBack == '0 && auxPulse == '0 && !auxLatch && isolateInd)
		else $error("output escaped isolate");
	a_mem_guard: assert property (store && st_r.memIso |=> progMem[lastIdx] == $past(memAtIdx))
		else $error("memory written while isolated");
	a_override_keeps: assert property (commit && st_r.seqRun && st_r.kbdOvr && st_r.play
		|-> kbdGo ##1 st_r.seqRun) else $error("override broke playback");
	a_tape_off: assert property (!st_r.tapeOn |=> !tapeRecValid)
		else $error("tape recorded while off");
	a_count_step: assert property (store |=> cueCount == bcdInc($past(cueCount)))
		else $error("cue counter missed a cue");
	a_seq_rate: assert property ($rose(st_r.seqDue) |-> $past(st_r.seqCnt) ==
		24'(SEQ_CYC) - 24'h000001) else $error("sequence tick off rate");
	a_aux_pulse: assert property (exGo && ex.cmd == CMD_AUX && ex.screens != 3'h0 && !isoNxt
		|=> auxPulse == $past(ex.screens) ##1 auxPulse == 3'h0)
		else $error("aux pulse wrong");
	a_aux_toggle: assert property (exGo && ex.cmd == CMD_AUX && ex.screens == 3'h0
		&& st_r.auxFit |=> st_r.auxLatchSt != $past(st_r.auxLatchSt))
		else $error("latching aux did not toggle");
endmodule

// file: hdl/pcd_defs.svh
`ifndef PCD_DEFS_SVH
`define PCD_DEFS_SVH
/*
 Offsets, field positions, reset values and timing figures of the cue command decoder.
 Assumes a 25 MHz system clock and a 12-bit APB byte address.
*/

`define PCD_CLK_HZ        25000000
`define PCD_BLEND_SHORT_S 2
`define PCD_BLEND_MED_S   4
`define PCD_BLEND_LONG_S  8
`define PCD_LVL_STEPS     256
`define PCD_SEQ_RATE_HZ   10
`define PCD_CUE_START     12'h001
`define PCD_MEM_DEPTH     16

`define PCD_ADDR_PANEL    12'h000
`define PCD_ADDR_STAGE    12'h004
`define PCD_ADDR_STATUS   12'h008
`define PCD_ADDR_TRAY     12'h00c

`define PCD_PNL_OVR       0
`define PCD_PNL_MEMISO    1
`define PCD_PNL_REMISO    2
`define PCD_PNL_DMODE_LO  3
`define PCD_PNL_DMODE_HI  4
`define PCD_PNL_PLAY      5
`define PCD_PNL_TAPEON    6
`define PCD_PNL_TAPEREC   7
`define PCD_PNL_AUXFIT    8

`define PCD_STG_ENTRY_HI  8
`define PCD_STG_CUE       16
`define PCD_STG_HOME      17
`endif

// file: hdl/pcd_pkg.sv
/*
 Types shared by the cue command decoder and its screen channels.
 Assumes pcd_defs.svh for all numeric constants.
*/
package pcd_pkg;
	typedef enum logic [3:0] {
		CMD_NONE, CMD_CUT, CMD_BLEND_SHORT, CMD_BLEND_MEDIUM, CMD_BLEND_LONG,
		CMD_LAMP_SWAP, CMD_TRAY_ADVANCE, CMD_TRAY_BACK, CMD_AUX, CMD_START, CMD_STOP
	} pcd_cmd_t;
	typedef enum logic [1:0] {DM_NORMAL, DM_STANDBY, DM_ISOLATE} pcd_dmode_t;
	typedef struct packed {
		logic       right;
		logic       left;
		logic [2:0] screens;
		logic [3:0] cmd;
	} pcd_entry_t;
	typedef struct packed {
		logic        litL, litR, pendL, pendR;
		logic [7:0]  lvlL, lvlR, oLvlL, oLvlR;
		logic [23:0] stepCnt, stepLen;
		logic [3:0]  posL, posR;
		logic        oAdvL, oAdvR, oBackL, oBackR;
	} pcd_chan_st_t;
	typedef struct packed {
		logic        kbdOvr, memIso, remIso, play, tapeOn, tapeRec, auxFit;
		logic [1:0]  dmode;
		pcd_entry_t  stage;
		logic [11:0] cueBcd;
		logic [3:0]  cueIdx;
		logic        seqRun, seqDue;
		logic [23:0] seqCnt;
		logic        auxLatchSt, auxLatchOut, remInd, isoInd, recValid;
		logic [2:0]  auxOut;
		pcd_entry_t  recData;
		logic [31:0] prdata;
	} pcd_top_st_t;
endpackage

// file: hdl/pcd_chan_if.sv
/*
 Link between the decoder core and one screen channel.
 Assumes one instance per projector pair.
*/
`timescale 1ns/1ps
interface pcd_chan_if;
	logic       go, selL, selR, lampsOff, outIsolate;
	logic [3:0] cmd;
	logic [7:0] lvlL, lvlR;
	logic       advL, advR, backL, backR, litL, litR, busy;
	logic [3:0] posL, posR;
	modport ctrl (output go, cmd, selL, selR, lampsOff, outIsolate,
		input lvlL, lvlR, advL, advR, backL, backR, litL, litR, busy, posL, posR);
	modport chan (input go, cmd, selL, selR, lampsOff, outIsolate,
		output lvlL, lvlR, advL, advR, backL, backR, litL, litR, busy, posL, posR);
endinterface

// file: hdl/pcd_channel.sv
/*
 One screen channel: lamp blend between a projector pair and tray tracking.
 Assumes a one-cycle go strobe from the decoder core.
*/
`timescale 1ns/1ps
`include "pcd_defs.svh"
module pcd_channel
	import pcd_pkg::*;
#(
	parameter int unsigned SHORT_CYC = 1,
	parameter int unsigned MED_CYC   = 1,
	parameter int unsigned LONG_CYC  = 1
)(
	input wire logic sys_clk,
	input wire logic reset_n,
	pcd_chan_if.chan ch
);
	pcd_chan_st_t st_r, st_nxt;
	logic [1:0]   mask, newLit, dark, sel;
	logic         trans, ramping, tick, tray, tray_advance_cmd;

	always_comb begin
		st_nxt = st_r;
		{st_nxt.oAdvL, st_nxt.oAdvR, st_nxt.oBackL, st_nxt.oBackR} = 4'h0;
		trans = ch.go && ch.cmd inside {CMD_CUT, CMD_BLEND_SHORT, CMD_BLEND_MEDIUM,
			CMD_BLEND_LONG, CMD_LAMP_SWAP};
		mask = (ch.selL || ch.selR) ? {ch.selL, ch.selR} :
			(st_r.litL || st_r.litR) ? 2'b11 : 2'b10;
		newLit = {st_r.litL, st_r.litR} ^ mask;
		dark = {st_r.litL, st_r.litR} & ~newLit;
		ramping = (st_r.lvlL != {8{st_r.litL}}) || (st_r.lvlR != {8{st_r.litR}});
		tick = ramping && (st_r.stepCnt >= st_r.stepLen - 24'h000001);
		if (ramping) begin
			st_nxt.stepCnt = tick ? 24'h000000 : st_r.stepCnt + 24'h000001;
			if (tick) begin
				if (st_r.lvlL != {8{st_r.litL}})
					st_nxt.lvlL = st_r.litL ? st_r.lvlL + 8'h01 : st_r.lvlL - 8'h01;
				if (st_r.lvlR != {8{st_r.litR}})
					st_nxt.lvlR = st_r.litR ? st_r.lvlR + 8'h01 : st_r.lvlR - 8'h01;
			end
		end else if (st_r.pendL || st_r.pendR) begin
			{st_nxt.oAdvL, st_nxt.oAdvR} = {st_r.pendL, st_r.pendR};
			st_nxt.posL = st_r.posL + {3'h0, st_r.pendL};
			st_nxt.posR = st_r.posR + {3'h0, st_r.pendR};
			{st_nxt.pendL, st_nxt.pendR} = 2'b00;
		end
		if (trans) begin
			{st_nxt.litL, st_nxt.litR} = newLit;
			st_nxt.stepCnt = 24'h000000;
			unique case (ch.cmd)
				CMD_BLEND_SHORT:  st_nxt.stepLen = 24'(SHORT_CYC);
				CMD_BLEND_MEDIUM: st_nxt.stepLen = 24'(MED_CYC);
				CMD_BLEND_LONG:   st_nxt.stepLen = 24'(LONG_CYC);
				default: begin
					st_nxt.lvlL = {8{newLit[1]}};
					st_nxt.lvlR = {8{newLit[0]}};
				end
			endcase
			if (ch.cmd != CMD_LAMP_SWAP)
				{st_nxt.pendL, st_nxt.pendR} = {st_nxt.pendL, st_nxt.pendR} | dark;
		end
		tray = ch.go && (ch.cmd == CMD_TRAY_ADVANCE || ch.cmd == CMD_TRAY_BACK);
		tray_advance_cmd = ch.cmd == CMD_TRAY_ADVANCE;
		sel = (ch.selL || ch.selR) ? {ch.selL, ch.selR} : 2'b11;
		if (tray && sel[1]) begin
			st_nxt.posL = tray_advance_cmd ? st_nxt.posL + 4'h1 : st_nxt.posL - 4'h1;
			st_nxt.oAdvL = st_nxt.oAdvL || tray_advance_cmd;
			st_nxt.oBackL = !tray_advance_cmd;
		end
		if (tray && sel[0]) begin
			st_nxt.posR = tray_advance_cmd ? st_nxt.posR + 4'h1 : st_nxt.posR - 4'h1;
			st_nxt.oAdvR = st_nxt.oAdvR || tray_advance_cmd;
			st_nxt.oBackR = !tray_advance_cmd;
		end
		// Tracking above runs on regardless; only what leaves the pins is muted.
		st_nxt.oLvlL = (ch.lampsOff || ch.outIsolate) ? 8'h00 : st_nxt.lvlL;
		st_nxt.oLvlR = (ch.lampsOff || ch.outIsolate) ? 8'h00 : st_nxt.lvlR;
		if (ch.outIsolate)
			{st_nxt.oAdvL, st_nxt.oAdvR, st_nxt.oBackL, st_nxt.oBackR} = 4'h0;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign ch.lvlL  = st_r.oLvlL;
	assign ch.lvlR  = st_r.oLvlR;
	assign ch.advL  = st_r.oAdvL;
	assign ch.advR  = st_r.oAdvR;
	assign ch.backL = st_r.oBackL;
	assign ch.backR = st_r.oBackR;
	assign ch.litL  = st_r.litL;
	assign ch.litR  = st_r.litR;
	assign ch.posL  = st_r.posL;
	assign ch.posR  = st_r.posR;
	assign ch.busy  = ramping || st_r.pendL || st_r.pendR;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_cut;
		ch.go && ch.cmd == CMD_CUT && !ch.busy && (st_r.litL || st_r.litR);
	endsequence
	a_cut_advance: assert property (s_cut |-> ##2 (st_r.posL != $past(st_r.posL, 2)
		|| st_r.posR != $past(st_r.posR, 2))) else $error("cut did not advance");
	a_swap_no_advance: assert property (ch.go && ch.cmd == CMD_LAMP_SWAP && !ch.busy
		|=> ($stable(st_r.posL) && $stable(st_r.posR))[*2]) else $error("swap moved tray");
	a_first_left: assert property (trans && !st_r.litL && !st_r.litR && !ch.selL && !ch.selR
		|=> st_r.litL && !st_r.litR) else $error("pair did not start left");
	a_advance_both: assert property (ch.go && ch.cmd == CMD_TRAY_ADVANCE && !ch.selL
		&& !ch.selR && !ch.busy |=> st_r.posL == $past(st_r.posL) + 4'h1
		&& st_r.posR == $past(st_r.posR) + 4'h1) else $error("advance missed a tray");
	a_back_selected: assert property (ch.go && ch.cmd == CMD_TRAY_BACK && ch.selL && !ch.selR
		&& !ch.busy |=> st_r.posL == $past(st_r.posL) - 4'h1 && $stable(st_r.posR))
		else $error("back hit wrong tray");
	a_standby_dark: assert property (ch.lampsOff |=> ch.lvlL == 8'h00 && ch.lvlR == 8'h00)
		else $error("lamp lit in standby");
	a_blend_busy: assert property (ch.go && ch.cmd == CMD_BLEND_LONG
		&& (st_r.litL || st_r.litR) && !ch.selL && !ch.selR |=> ch.busy [*2])
		else $error("blend ended at once");
endmodule

// file: tb/pcd_pack_model.sv
/*
 Far-side model of the projector power packs and aux equipment: counts tray pulses
 per projector and aux pulses per channel and records the tape echo of executed entries.
 Assumes registered one-cycle pulses from the decoder on sys_clk.
*/
`timescale 1ns/1ps
module pcd_pack_model (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic [5:0]  trayAdvance,
	input  wire logic [5:0]  trayBack,
	input  wire logic [2:0]  auxPulse,
	input  wire logic        tapeRecValid,
	input  wire logic [8:0]  tapeRecData,
	output logic      [47:0] advCnt,
	output logic      [47:0] backCnt,
	output logic      [47:0] auxCnt,
	output logic      [7:0]  recCnt,
	output logic      [8:0]  recLast
);
	// A pack only counts pulses, so a pulse that lasts two cycles shows as two steps.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			advCnt <= '0;
			backCnt <= '0;
			auxCnt <= '0;
			recCnt <= '0;
			recLast <= '0;
		end else begin
			for (int i = 0; i < 6; i++) begin
				advCnt[8*i +: 8] <= advCnt[8*i +: 8] + {7'h00, trayAdvance[i]};
				backCnt[8*i +: 8] <= backCnt[8*i +: 8] + {7'h00, trayBack[i]};
			end
			for (int i = 0; i < 3; i++) begin
				auxCnt[8*i +: 8] <= auxCnt[8*i +: 8] + {7'h00, auxPulse[i]};
			end
			if (tapeRecValid) begin
				recCnt <= recCnt + 8'h01;
				recLast <= tapeRecData;
			end
		end
	end
endmodule

// file: tb/pcd_cue_decoder_tb_top.sv
/*
 Self-checking bench of the cue command decoder: APB panel and stage tasks,
 remote cue pulses and pulse counting through the pack model.
 Assumes short blend and sequence parameters so the longest blend finishes in 1020 cycles.
*/
`timescale 1ns/1ps
`include "pcd_defs.svh"
module pcd_cue_decoder_tb_top;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        remoteCue = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        tapePlayValid = 1'b0;
	logic [8:0]  tapePlayData = 9'h000;
	wire  [31:0] prdata;
	wire         pready, pslverr, remoteInd, isolateInd, tapeRecValid, auxLatch;
	wire  [8:0]  tapeRecData, recLast;
	wire  [47:0] lampLevel, advCnt, backCnt, auxCnt;
	wire  [5:0]  trayAdvance, trayBack;
	wire  [2:0]  auxPulse;
	wire  [11:0] cueCount;
	wire  [7:0]  recCnt;
	int          failures = 0;
	int          compares = 0;
	int          cyc = 0;
	int          n;
	logic [47:0] expAdv = '0;
	logic [47:0] expBack = '0;
	logic [47:0] expAux = '0;
	logic [31:0] rd, t0;
	logic [15:0] tgt;
	logic        err;

	pcd_cue_decoder #(.SEQ_CYC(8), .BLEND_SHORT_CYC(2), .BLEND_MED_CYC(3), .BLEND_LONG_CYC(4)) dut (
		.sys_clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .remoteCue, .remoteInd, .isolateInd, .tapePlayValid, .tapePlayData,
		.tapeRecValid, .tapeRecData, .lampLevel, .trayAdvance, .trayBack, .auxPulse,
		.auxLatch, .cueCount);
	pcd_pack_model pack (.sys_clk, .reset_n, .trayAdvance, .trayBack, .auxPulse,
		.tapeRecValid, .tapeRecData, .advCnt, .backCnt, .auxCnt, .recCnt, .recLast);

	always #20 sys_clk = ~sys_clk;

	task automatic results();
		if (failures == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			results();
		end
	end

	task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [47:0] bump(input logic [47:0] v, input logic [5:0] m);
		for (int i = 0; i < 6; i++) begin
			if (m[i]) begin
				v[8*i +: 8] = v[8*i +: 8] + 8'h01;
			end
		end
		return v;
	endfunction

	// The request is held until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait for pready.
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cue(input logic [31:0] e);
		apb(1'b1, `PCD_ADDR_STAGE, 32'h10000 | e);
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic cnts();
		chk("advance", advCnt, expAdv);
		chk("back", backCnt, expBack);
		chk("aux", auxCnt, expAux);
	endtask

	task automatic remote();
		@(posedge sys_clk);
		remoteCue <= 1'b1;
		@(posedge sys_clk);
		remoteCue <= 1'b0;
		@(posedge sys_clk);
		chk("remoteInd", remoteInd, 1'b1);
		repeat (3) @(posedge sys_clk);
	endtask

	initial begin
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		chk("cueCount", cueCount, 12'h001);
		apb(1'b1, `PCD_ADDR_PANEL, 32'h1c0);
		apb(1'b1, `PCD_ADDR_STAGE, 32'h011);
		repeat (4) @(posedge sys_clk);
		chk("lamp", lampLevel, 48'h0);
		apb(1'b0, `PCD_ADDR_STAGE, 32'h0);
		chk("stage", rd, 32'h011);
		cue(32'h0);
		chk("lamp", lampLevel, 48'hff);
		apb(1'b0, `PCD_ADDR_STAGE, 32'h0);
		chk("stage", rd, 32'h0);
		chk("recLast", recLast, 9'h011);
		cue(32'h011);
		expAdv = bump(expAdv, 6'h01);
		chk("lamp", lampLevel, 48'hff00);
		cnts();
		cue(32'h015);
		chk("lamp", lampLevel, 48'hff);
		cnts();
		cue(32'h066);
		cue(32'h0a6);
		cue(32'h147);
		cue(32'h017);
		expAdv = bump(bump(expAdv, 6'h3c), 6'h04);
		expBack = bump(bump(expBack, 6'h20), 6'h03);
		cnts();
		cue(32'h058);
		expAux = bump(expAux, 6'h05);
		cnts();
		cue(32'h008);
		chk("auxLatch", auxLatch, 1'b1);
		cue(32'h008);
		chk("auxLatch", auxLatch, 1'b0);
		apb(1'b1, `PCD_ADDR_PANEL, 32'h1c4);
		apb(1'b1, `PCD_ADDR_STAGE, 32'h016);
		remote();
		cnts();
		apb(1'b1, `PCD_ADDR_PANEL, 32'h1c0);
		apb(1'b1, `PCD_ADDR_STAGE, 32'h016);
		remote();
		expAdv = bump(expAdv, 6'h03);
		cnts();
		apb(1'b1, `PCD_ADDR_PANEL, 32'h1d0);
		apb(1'b0, `PCD_ADDR_TRAY, 32'h0);
		t0 = rd;
		cue(32'h046);
		cnts();
		chk("isolateInd", isolateInd, 1'b1);
		chk("lamp", lampLevel, 48'h0);
		apb(1'b0, `PCD_ADDR_TRAY, 32'h0);
		chk("tray", rd, t0 + 32'h110000);
		apb(1'b1, `PCD_ADDR_PANEL, 32'h1c8);
		cue(32'h011);
		expAdv = bump(expAdv, 6'h01);
		cnts();
		chk("lamp", lampLevel, 48'h0);
		apb(1'b0, `PCD_ADDR_STATUS, 32'h0);
		chk("lit", rd[22:17], 6'h02);
		apb(1'b1, `PCD_ADDR_PANEL, 32'h1c0);
		repeat (2) @(posedge sys_clk);
		chk("lamp", lampLevel, 48'hff00);
		for (int k = 0; k < 3; k++) begin
			tgt = (k == 1) ? 16'hff00 : 16'h00ff;
			cue(32'h022 + k);
			chk("blendEarly", lampLevel[31:16] == tgt, 1'b0);
			n = 0;
			while (lampLevel[31:16] !== tgt && n < 1500) begin
				@(posedge sys_clk);
				n++;
			end
			repeat (4) @(posedge sys_clk);
			expAdv = bump(expAdv, (k == 0) ? 6'h00 : 6'h04 << (k - 1));
			chk("blend", lampLevel[31:16], tgt);
			cnts();
		end
		apb(1'b1, `PCD_ADDR_PANEL, 32'h140);
		t0 = recCnt;
		cue(32'h016);
		apb(1'b1, `PCD_ADDR_PANEL, 32'h080);
		cue(32'h016);
		chk("recCnt", recCnt, t0);
		apb(1'b1, `PCD_ADDR_PANEL, 32'h1c0);
		apb(1'b1, `PCD_ADDR_STAGE, 32'h20000);
		for (int k = 0; k < 10; k++) begin
			cue(32'h016);
		end
		expAdv = bump(bump(expAdv, 6'h03), 6'h03);
		for (int k = 0; k < 10; k++) begin
			expAdv = bump(expAdv, 6'h03);
		end
		cnts();
		chk("cueCount", cueCount, 12'h011);
		cue(32'h00a);
		apb(1'b1, `PCD_ADDR_STAGE, 32'h20000);
		apb(1'b1, `PCD_ADDR_PANEL, 32'h1c2);
		cue(32'h046);
		expAdv = bump(expAdv, 6'h30);
		chk("cueCount", cueCount, 12'h002);
		apb(1'b1, `PCD_ADDR_STAGE, 32'h20000);
		apb(1'b1, `PCD_ADDR_PANEL, 32'h1e3);
		cue(32'h009);
		cue(32'h0c7);
		expBack = bump(expBack, 6'h10);
		repeat (120) @(posedge sys_clk);
		for (int k = 0; k < 10; k++) begin
			expAdv = bump(expAdv, 6'h03);
		end
		cnts();
		chk("cueCount", cueCount, 12'h012);
		apb(1'b0, `PCD_ADDR_STATUS, 32'h0);
		chk("seqRun", rd[13], 1'b0);
		apb(1'b0, 12'h010, 32'h0);
		chk("slverr", err, 1'b1);
		chk("rdata", rd, 32'h0);
		results();
	end
endmodule
